// [hw/fhbs_pkg.sv]
// Purpose: Shared constants and types for the flash host bus pin logic.
// Assumes: System clock of 200 MHz; pins are active low except the enables.
// Notes: Times are held in ns and turned into cycle counts here.
package fhbs_pkg;

  // Bus widths
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int BUSY_BIT = 7;

  // Clock rate and documented times
  localparam int SYS_CLK_MHZ = 200;
  localparam int RESET_RECOVERY_NS = 100;
  localparam int STS_PULSE_NS = 250;

  // Least times, rounded up to whole cycles
  localparam logic [7:0] RECOVERY_CYC = 8'((RESET_RECOVERY_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [7:0] STS_PULSE_CYC = 8'((STS_PULSE_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_MAX = 8'hFF;

  // Values after reset
  localparam logic RST_READ_ASYNC = 1'b1;
  localparam logic RST_EDGE_FALLING = 1'b0;
  localparam logic RST_BURST_CONT = 1'b0;
  localparam logic RST_VDR_EARLY = 1'b0;
  localparam logic RST_STS_PULSE = 1'b0;
  localparam logic [ADDR_W-1:0] RST_ADDR = 21'h000000;
  localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;

  // Idle pin levels seen by the synchronisers: ce, oe, we, le high; reset low, allow low
  localparam logic [5:0] RST_CTRL_PINS = 6'h0F;
  localparam int PIN_CE = 0;
  localparam int PIN_OE = 1;
  localparam int PIN_WE = 2;
  localparam int PIN_LE = 3;
  localparam int PIN_RP = 4;
  localparam int PIN_PE = 5;

  // Link side configuration bits
  localparam int KCFG_SYNC = 0;
  localparam int KCFG_CONT = 1;
  localparam int KCFG_EARLY = 2;
  localparam logic [2:0] RST_KCFG = 3'h0;

  // Source that a bus read presents
  typedef enum logic [2:0] {
    SRC_ARRAY,
    SRC_SIGNATURE,
    SRC_PROTECT,
    SRC_QUERY,
    SRC_STATUS
  } fhbs_rd_src_t;

  // Reset and recovery phase
  typedef enum logic [1:0] {
    RP_DOWN,
    RP_RECOVER,
    RP_READY
  } fhbs_rp_state_t;

endpackage : fhbs_pkg

// [hw/fhbs_sync3.sv]
// Purpose: Three flop synchroniser with agreement filter for pin inputs.
// Assumes: The destination clock is free running while the value matters.
// Notes: A bit of the output changes once stages two and three agree.
`timescale 1ns/1ps
module fhbs_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  import fhbs_pkg::*;

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] q_ff;
  wire logic [WIDTH-1:0] agree;
  wire logic [WIDTH-1:0] nxt_q;

  // Per bit agreement of the last two stages
  assign agree = ~(s2_ff ^ s3_ff);
  assign nxt_q = (s3_ff & agree) | (q_ff & ~agree);
  assign q_out = q_ff;

  // Synchroniser chain; the first stage feeds only the second
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      s1_ff <= d_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

endmodule : fhbs_sync3

// [hw/fhbs_top.sv]
// Purpose: Pin side logic of a parallel flash host bus, device end.
// Assumes: Core logic decodes commands; in synchronous reads the bus pins are synchronous to the burst clock.
// Notes: Async strobes are sampled at 200 MHz; the burst path runs on the burst clock.
// Behaviour
// - Write address taken at first rising of chip select, write strobe or latch.
// - Address latch follows the pins while the latch strobe is low.
// - Operation target address held once program or erase starts.
// - Write data taken at first rising of write strobe or chip select.
// - Read drives data from the source chosen by the previous command.
// - Data pins undriven when deselected, output gate high or reset low.
// - Busy controller shows busy as a low data bit seven in asynchronous reads.
// - Output gate high suppresses data during a burst read.
// - Reset low clears status, deselects the device and powers it down.
// - Reset during an operation aborts it; busy stays low until reset ends.
// - Bus accesses accepted only after the reset recovery time.
// - Sync address taken on first active clock edge with latch low.
// - Active burst clock edge selectable as rising or falling.
// - Burst clock ignored in asynchronous operation.
// - Valid data ready driven only in continuous synchronous burst reads.
// - Valid data ready low on the invalid cycle or one cycle early.
// - Ready/busy mode pulls status low throughout program and erase.
// - Pulse mode emits a pulse at the end of program or erase.
// - Status output starts in ready/busy mode; a command selects pulse mode.
// - Status not low in reset unless reset came while busy.
// - Program and erase blocked while the enable input is low.
// - Chip select high deselects the device into standby.
// - Reset returns the device to asynchronous read mode.
// - Read mode bit one selects asynchronous, zero synchronous reads.
`timescale 1ns/1ps
module fhbs_top (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic burst_clk_in,
  input wire logic chip_sel_n_in,
  input wire logic out_gate_n_in,
  input wire logic write_strobe_n_in,
  input wire logic addr_latch_n_in,
  input wire logic reset_powerdown_n_in,
  input wire logic program_erase_allow_in,
  input wire logic [fhbs_pkg::ADDR_W-1:0] word_address_in,
  input wire logic [fhbs_pkg::DATA_W-1:0] bidir_data_bus_in,
  output logic [fhbs_pkg::DATA_W-1:0] bidir_data_bus_out,
  output logic bidir_data_bus_oe_out,
  output logic valid_data_ready_out,
  output logic valid_data_ready_oe_out,
  output logic controller_state_out,
  output logic controller_state_oe_out,
  output logic cmd_strobe_out,
  output logic [fhbs_pkg::ADDR_W-1:0] cmd_addr_out,
  output logic [fhbs_pkg::DATA_W-1:0] cmd_data_out,
  output logic [fhbs_pkg::ADDR_W-1:0] read_addr_out,
  input wire fhbs_pkg::fhbs_rd_src_t read_source_in,
  input wire logic [fhbs_pkg::DATA_W-1:0] array_data_in,
  input wire logic [fhbs_pkg::DATA_W-1:0] signature_data_in,
  input wire logic [fhbs_pkg::DATA_W-1:0] protect_data_in,
  input wire logic [fhbs_pkg::DATA_W-1:0] query_data_in,
  input wire logic [fhbs_pkg::DATA_W-1:0] status_data_in,
  input wire logic pe_busy_in,
  input wire logic pe_done_in,
  output logic [fhbs_pkg::ADDR_W-1:0] op_addr_out,
  output logic pe_abort_out,
  output logic pe_permit_out,
  output logic status_clear_out,
  output logic powerdown_out,
  output logic standby_out,
  output logic bus_ready_out,
  input wire logic cfg_wr_in,
  input wire logic cfg_read_async_in,
  input wire logic cfg_edge_falling_in,
  input wire logic cfg_burst_cont_in,
  input wire logic cfg_vdr_early_in,
  input wire logic sts_cfg_wr_in,
  input wire logic sts_cfg_pulse_in,
  output logic read_mode_select_bit_out,
  output logic [fhbs_pkg::ADDR_W-1:0] burst_addr_out,
  output logic burst_active_out,
  input wire logic [fhbs_pkg::DATA_W-1:0] burst_data_in,
  input wire logic burst_word_ready_in
);
  import fhbs_pkg::*;

  // ---------------- System domain ----------------
  wire logic [5:0] ctrl_f;
  wire logic [ADDR_W-1:0] addr_f;
  wire logic [DATA_W-1:0] data_f;
  logic ce_d_ff;
  logic we_d_ff;
  logic rp_d_ff;
  logic busy_d_ff;
  logic [ADDR_W-1:0] lat_addr_ff;
  logic cmd_strobe_ff;
  logic [ADDR_W-1:0] cmd_addr_ff;
  logic [DATA_W-1:0] cmd_data_ff;
  logic [ADDR_W-1:0] op_addr_ff;
  logic [DATA_W-1:0] rd_data_ff;
  logic drive_async_ff;
  logic burst_gate_ff;
  logic vdr_gate_ff;
  logic abort_ff;
  logic sts_hold_ff;
  logic sts_pulse_ff;
  logic [7:0] sts_cnt_ff;
  logic read_mode_ff;
  logic edge_falling_ff;
  logic burst_cont_ff;
  logic vdr_early_ff;
  logic [7:0] rec_cnt_ff;
  fhbs_rp_state_t rp_state_ff;
  fhbs_rp_state_t nxt_rp_state;
  logic [7:0] nxt_rec_cnt;

  // Pin synchronisers for control, address and data
  fhbs_sync3 #(.WIDTH(6), .RST_VAL(RST_CTRL_PINS)) u_sync_ctrl (
    .clk_in(clk_sys_in),
    .rst_in(sys_rst_in),
    .d_in({program_erase_allow_in, reset_powerdown_n_in, addr_latch_n_in,
           write_strobe_n_in, out_gate_n_in, chip_sel_n_in}),
    .q_out(ctrl_f)
  );
  fhbs_sync3 #(.WIDTH(ADDR_W), .RST_VAL(RST_ADDR)) u_sync_addr (
    .clk_in(clk_sys_in),
    .rst_in(sys_rst_in),
    .d_in(word_address_in),
    .q_out(addr_f)
  );
  fhbs_sync3 #(.WIDTH(DATA_W), .RST_VAL(RST_DATA)) u_sync_data (
    .clk_in(clk_sys_in),
    .rst_in(sys_rst_in),
    .d_in(bidir_data_bus_in),
    .q_out(data_f)
  );

  // Decoded pin levels and events
  wire logic ce_f = ctrl_f[PIN_CE];
  wire logic oe_f = ctrl_f[PIN_OE];
  wire logic we_f = ctrl_f[PIN_WE];
  wire logic le_f = ctrl_f[PIN_LE];
  wire logic rp_f = ctrl_f[PIN_RP];
  wire logic allow_f = ctrl_f[PIN_PE];
  wire logic bus_ready = (rp_state_ff == RP_READY);
  wire logic end_write = ~ce_d_ff & ~we_d_ff & (ce_f | we_f);
  wire logic rp_fall = rp_d_ff & ~rp_f;
  wire logic busy_rise = pe_busy_in & ~busy_d_ff;
  wire logic read_sel = bus_ready & rp_f & ~ce_f & ~oe_f;
  wire logic [ADDR_W-1:0] wr_addr = le_f ? lat_addr_ff : addr_f;

  // Source picked by the previous command
  wire logic [DATA_W-1:0] src_data =
    (read_source_in == SRC_SIGNATURE) ? signature_data_in :
    (read_source_in == SRC_PROTECT) ? protect_data_in :
    (read_source_in == SRC_QUERY) ? query_data_in :
    (read_source_in == SRC_STATUS) ? status_data_in : array_data_in;
  wire logic [DATA_W-1:0] nxt_rd_data = pe_busy_in ?
    (src_data & ~(16'h0001 << BUSY_BIT)) : src_data;

  // Reset phase sequencing with recovery count
  always_comb begin
    nxt_rp_state = rp_state_ff;
    nxt_rec_cnt = rec_cnt_ff;
    case (rp_state_ff)
      RP_DOWN: begin
        nxt_rec_cnt = CNT_ZERO;
        if (rp_f) begin
          nxt_rp_state = RP_RECOVER;
        end
      end
      RP_RECOVER: begin
        if (!rp_f) begin
          nxt_rp_state = RP_DOWN;
        end else if (rec_cnt_ff == RECOVERY_CYC - CNT_ONE) begin
          nxt_rp_state = RP_READY;
        end else begin
          nxt_rec_cnt = rec_cnt_ff + CNT_ONE;
        end
      end
      RP_READY: begin
        if (!rp_f) begin
          nxt_rp_state = RP_DOWN;
        end
      end
      default: begin
        nxt_rp_state = RP_DOWN;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rp_state_ff <= RP_DOWN;
      rec_cnt_ff <= CNT_ZERO;
    end else begin
      rp_state_ff <= nxt_rp_state;
      rec_cnt_ff <= nxt_rec_cnt;
    end
  end

  // Delayed strobes for edge detection
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ce_d_ff <= 1'b1;
      we_d_ff <= 1'b1;
      rp_d_ff <= 1'b0;
      busy_d_ff <= 1'b0;
    end else begin
      ce_d_ff <= ce_f;
      we_d_ff <= we_f;
      rp_d_ff <= rp_f;
      busy_d_ff <= pe_busy_in;
    end
  end

  // Transparent address latch, frozen while the latch strobe is high
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lat_addr_ff <= RST_ADDR;
    end else if (!le_f) begin
      lat_addr_ff <= addr_f;
    end
  end

  // Command capture at the end of a write
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmd_strobe_ff <= 1'b0;
      cmd_addr_ff <= RST_ADDR;
      cmd_data_ff <= RST_DATA;
    end else begin
      cmd_strobe_ff <= end_write & bus_ready & rp_f;
      if (end_write & bus_ready & rp_f) begin
        cmd_addr_ff <= wr_addr;
        cmd_data_ff <= data_f;
      end
    end
  end

  // Target address held for the running operation
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      op_addr_ff <= RST_ADDR;
    end else if (busy_rise) begin
      op_addr_ff <= cmd_addr_ff;
    end
  end

  // Read data and drive gates
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_ff <= RST_DATA;
      drive_async_ff <= 1'b0;
      burst_gate_ff <= 1'b0;
      vdr_gate_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      drive_async_ff <= read_sel & read_mode_ff;
      burst_gate_ff <= read_sel & ~read_mode_ff;
      vdr_gate_ff <= bus_ready & rp_f & ~ce_f & ~read_mode_ff;
    end
  end

  // Configuration held in the device; reset pin restores defaults
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      read_mode_ff <= RST_READ_ASYNC;
      edge_falling_ff <= RST_EDGE_FALLING;
      burst_cont_ff <= RST_BURST_CONT;
      vdr_early_ff <= RST_VDR_EARLY;
      sts_pulse_ff <= RST_STS_PULSE;
    end else if (!rp_f) begin
      read_mode_ff <= RST_READ_ASYNC;
      edge_falling_ff <= RST_EDGE_FALLING;
      burst_cont_ff <= RST_BURST_CONT;
      vdr_early_ff <= RST_VDR_EARLY;
      sts_pulse_ff <= RST_STS_PULSE;
    end else begin
      if (cfg_wr_in & bus_ready) begin
        read_mode_ff <= cfg_read_async_in;
        edge_falling_ff <= cfg_edge_falling_in;
        burst_cont_ff <= cfg_burst_cont_in;
        vdr_early_ff <= cfg_vdr_early_in;
      end
      if (sts_cfg_wr_in & bus_ready) begin
        sts_pulse_ff <= sts_cfg_pulse_in;
      end
    end
  end

  // Abort on reset entry while busy, and hold status low for the pulse
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      abort_ff <= 1'b0;
      sts_hold_ff <= 1'b0;
    end else begin
      abort_ff <= rp_fall & pe_busy_in;
      if (rp_fall & pe_busy_in) begin
        sts_hold_ff <= 1'b1;
      end else if (rp_f) begin
        sts_hold_ff <= 1'b0;
      end
    end
  end

  // End of operation pulse timer
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sts_cnt_ff <= CNT_ZERO;
    end else if (!rp_f) begin
      sts_cnt_ff <= CNT_ZERO;
    end else if (pe_done_in & sts_pulse_ff) begin
      sts_cnt_ff <= STS_PULSE_CYC;
    end else if (sts_cnt_ff != CNT_ZERO) begin
      sts_cnt_ff <= sts_cnt_ff - CNT_ONE;
    end
  end

  // Open drain status pin
  wire logic sts_busy_low = pe_busy_in & rp_f;
  wire logic sts_pulse_low = sts_cnt_ff != CNT_ZERO;
  assign controller_state_out = 1'b0;
  assign controller_state_oe_out = sts_pulse_ff ? sts_pulse_low : (sts_busy_low | sts_hold_ff);

  // Core facing outputs
  assign cmd_strobe_out = cmd_strobe_ff;
  assign cmd_addr_out = cmd_addr_ff;
  assign cmd_data_out = cmd_data_ff;
  assign read_addr_out = lat_addr_ff;
  assign op_addr_out = op_addr_ff;
  assign pe_abort_out = abort_ff;
  assign pe_permit_out = allow_f & bus_ready;
  assign status_clear_out = ~rp_f;
  assign powerdown_out = ~rp_f;
  assign standby_out = rp_f & ce_f;
  assign bus_ready_out = bus_ready;
  assign read_mode_select_bit_out = read_mode_ff;

  // ---------------- Burst clock domain ----------------
  wire logic edge_k;
  wire logic [2:0] kcfg;
  wire logic k_clk;
  logic burst_on_ff;
  logic [ADDR_W-1:0] burst_addr_ff;
  logic [DATA_W-1:0] burst_data_ff;
  logic burst_oe_ff;
  logic vdr_low_ff;

  // Edge select crosses on the raw clock; change it only while the clock is idle
  fhbs_sync3 #(.WIDTH(1), .RST_VAL(RST_EDGE_FALLING)) u_sync_edge (
    .clk_in(burst_clk_in),
    .rst_in(sys_rst_in),
    .d_in(edge_falling_ff),
    .q_out(edge_k)
  );
  assign k_clk = burst_clk_in ^ edge_k;

  // Mode bits into the link domain
  fhbs_sync3 #(.WIDTH(3), .RST_VAL(RST_KCFG)) u_sync_kcfg (
    .clk_in(k_clk),
    .rst_in(sys_rst_in),
    .d_in({vdr_early_ff, burst_cont_ff, ~read_mode_ff}),
    .q_out(kcfg)
  );

  wire logic sync_k = kcfg[KCFG_SYNC];
  wire logic cont_k = kcfg[KCFG_CONT];
  wire logic early_k = kcfg[KCFG_EARLY];
  wire logic burst_start = sync_k & ~chip_sel_n_in & ~addr_latch_n_in & ~burst_on_ff;
  wire logic vdr_scope = sync_k & cont_k & burst_on_ff;
  wire logic vdr_low = early_k ? ~burst_word_ready_in : vdr_low_ff;
  wire logic vdr_oe_k = vdr_scope & vdr_low;

  // Burst flag and address; idle whenever the read mode is asynchronous
  always_ff @(posedge k_clk or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      burst_on_ff <= 1'b0;
      burst_addr_ff <= RST_ADDR;
    end else if (chip_sel_n_in | ~sync_k) begin
      burst_on_ff <= 1'b0;
    end else if (burst_start) begin
      burst_on_ff <= 1'b1;
      burst_addr_ff <= word_address_in;
    end else if (burst_on_ff & burst_word_ready_in) begin
      burst_addr_ff <= burst_addr_ff + 21'h000001;
    end
  end

  // Output word, its gate and the invalid marker
  always_ff @(posedge k_clk or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      burst_data_ff <= RST_DATA;
      burst_oe_ff <= 1'b0;
      vdr_low_ff <= 1'b0;
    end else begin
      burst_data_ff <= burst_data_in;
      burst_oe_ff <= sync_k & burst_on_ff & ~out_gate_n_in;
      vdr_low_ff <= ~burst_word_ready_in;
    end
  end

  assign burst_addr_out = burst_addr_ff;
  assign burst_active_out = burst_on_ff;

  // Pin drive; system side gates end the burst drive with the frame
  assign bidir_data_bus_out = read_mode_ff ? rd_data_ff : burst_data_ff;
  assign bidir_data_bus_oe_out = drive_async_ff | (burst_oe_ff & burst_gate_ff);
  assign valid_data_ready_out = 1'b0;
  assign valid_data_ready_oe_out = vdr_oe_k & vdr_gate_ff;

  // ---------------- Checks ----------------
  logic [7:0] rp_high_cnt_ff;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rp_high_cnt_ff <= CNT_ZERO;
    end else if (!rp_f) begin
      rp_high_cnt_ff <= CNT_ZERO;
    end else if (rp_high_cnt_ff != CNT_MAX) begin
      rp_high_cnt_ff <= rp_high_cnt_ff + CNT_ONE;
    end
  end

  chk_data_hiz: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ($past(ce_f) | $past(oe_f) | !$past(rp_f)) |-> !bidir_data_bus_oe_out)
    else $error("data pins driven while deselected or in reset");
  chk_write_data: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (end_write & bus_ready & rp_f) |=> cmd_strobe_out && cmd_data_out == $past(data_f))
    else $error("write data not captured at strobe rise");
  chk_write_addr: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (end_write & bus_ready & rp_f & !le_f) |=> cmd_addr_out == $past(addr_f))
    else $error("write address not captured");
  chk_op_addr_hold: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (pe_busy_in & busy_d_ff) |=> $stable(op_addr_out))
    else $error("operation address moved while busy");
  chk_busy_bit: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    pe_busy_in |=> !rd_data_ff[BUSY_BIT])
    else $error("busy not shown on data bit seven");
  chk_recover_wait: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (rp_high_cnt_ff <= RECOVERY_CYC) |-> !bus_ready_out)
    else $error("bus ready before recovery time");
  chk_recover_done: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (rp_high_cnt_ff == RECOVERY_CYC + CNT_ONE) |-> bus_ready_out)
    else $error("bus not ready after recovery time");
  chk_sts_busy: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (!sts_pulse_ff & pe_busy_in & rp_f) |-> controller_state_oe_out)
    else $error("status not low while busy");
  chk_sts_pulse: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (sts_pulse_ff & rp_f & pe_done_in) ##1 rp_f |-> controller_state_oe_out[*8])
    else $error("end of operation pulse too short");
  chk_reset_quiet: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ($fell(rp_f) && !pe_busy_in && !sts_hold_ff) ##1 !rp_f |-> !controller_state_oe_out)
    else $error("status low during idle reset");
  chk_reset_mode: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !rp_f |=> read_mode_ff && !sts_pulse_ff)
    else $error("reset did not restore default modes");
  chk_abort_pulse: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (rp_fall & pe_busy_in) |=> pe_abort_out ##1 !pe_abort_out)
    else $error("abort not signalled on reset while busy");
  chk_burst_start: assert property (@(posedge k_clk) disable iff (sys_rst_in)
    burst_start |=> burst_on_ff && burst_addr_ff == $past(word_address_in))
    else $error("burst address not taken on active edge");
  chk_vdr_scope: assert property (@(posedge k_clk) disable iff (sys_rst_in)
    !(sync_k && cont_k && $past(burst_start)) && !burst_on_ff |-> !valid_data_ready_oe_out)
    else $error("valid data ready driven outside burst");

endmodule : fhbs_top

// [dv/fhbs_host.sv]
// Purpose: Host model driving the flash bus pins.
// Assumes: Pins move just after a falling clock edge.
// Notes: Released data lines show the inverse value.
`timescale 1ns/1ps
module fhbs_host (
  input wire logic clk_in,
  output logic ce_n_out,
  output logic oe_n_out,
  output logic we_n_out,
  output logic le_n_out,
  output logic rp_n_out,
  output logic pe_out,
  output logic [20:0] addr_out,
  output logic [15:0] dq_out
);
  // Idle bus, reset pin low
  initial begin
    {ce_n_out, oe_n_out, we_n_out, le_n_out, rp_n_out, pe_out} = 6'h3C;
    {addr_out, dq_out} = '0;
  end
  // Reset pulse, then the allow level
  task automatic rst(input int n, input logic pe);
    rp_n_out <= 1'b0;
    repeat (n) @(negedge clk_in);
    {rp_n_out, pe_out} <= {1'b1, pe};
  endtask : rst
  // Write cycle, gate high throughout
  task automatic wr(input logic [20:0] a, input logic [15:0] d);
    {addr_out, dq_out, le_n_out, oe_n_out} <= {a, d, 2'h1};
    {ce_n_out, we_n_out} <= 2'h0;
    repeat (4) @(negedge clk_in);
    we_n_out <= 1'b1;
    repeat (4) @(negedge clk_in);
    {ce_n_out, dq_out} <= {1'b1, ~d};
    repeat (4) @(negedge clk_in);
  endtask : wr
  // Latch open, select and gate as given
  task automatic rd(input logic [20:0] a, input logic [1:0] cg, input int n);
    {addr_out, le_n_out, ce_n_out, oe_n_out} <= {a, 1'b0, cg};
    repeat (n) @(negedge clk_in);
  endtask : rd
endmodule : fhbs_host

// [dv/testbench.sv]
// Purpose: Self-checking bench for the flash bus pin logic.
// Assumes: Host model drives the pins.
// Notes: Expected words come from a local table.
`timescale 1ns/1ps
module testbench;
  import fhbs_pkg::*;
  logic clk_sys_in, sys_rst_in, burst_clk_in, chip_sel_n_in, out_gate_n_in, write_strobe_n_in;
  logic addr_latch_n_in, reset_powerdown_n_in, program_erase_allow_in, cmd_strobe_out;
  logic [20:0] word_address_in, cmd_addr_out, read_addr_out, op_addr_out, burst_addr_out, a;
  logic [15:0] bidir_data_bus_in, bidir_data_bus_out, array_data_in, signature_data_in;
  logic [15:0] protect_data_in, query_data_in, status_data_in, burst_data_in, host_dq, words [5];
  logic bidir_data_bus_oe_out, valid_data_ready_out, valid_data_ready_oe_out;
  logic controller_state_out, controller_state_oe_out, pe_busy_in, pe_done_in, pe_abort_out;
  logic pe_permit_out, status_clear_out, powerdown_out, standby_out, bus_ready_out, cfg_wr_in;
  logic cfg_read_async_in, cfg_edge_falling_in, cfg_burst_cont_in, cfg_vdr_early_in;
  logic sts_cfg_wr_in, sts_cfg_pulse_in, read_mode_select_bit_out, burst_active_out;
  logic burst_word_ready_in;
  logic [15:0] cmd_data_out;
  fhbs_rd_src_t read_source_in;
  int num_errors, checks, strobes, aborts, cnt, seed = 34367;
  // System clock
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // Device drive wins on the data pins
  assign bidir_data_bus_in = bidir_data_bus_oe_out ? bidir_data_bus_out : host_dq;
  fhbs_top fhbs_top_inst (.*);
  fhbs_host fhbs_host_inst (.clk_in(clk_sys_in), .ce_n_out(chip_sel_n_in),
    .oe_n_out(out_gate_n_in), .we_n_out(write_strobe_n_in), .le_n_out(addr_latch_n_in),
    .rp_n_out(reset_powerdown_n_in), .pe_out(program_erase_allow_in),
    .addr_out(word_address_in), .dq_out(host_dq));
  // Count one-cycle pulses
  always @(negedge clk_sys_in) begin
    strobes += cmd_strobe_out;
    aborts += pe_abort_out;
  end
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys_in);
    s = 1'b0;
  endtask : pulse
  // Burst clock cycles, idle low between frames
  task automatic kclk(input int n);
    repeat (n) begin
      #7.5 burst_clk_in = 1'b1;
      #7.5 burst_clk_in = 1'b0;
    end
  endtask : kclk
  // Main sequence
  initial begin
    {sys_rst_in, burst_clk_in, pe_busy_in, pe_done_in, cfg_wr_in, sts_cfg_wr_in} = 6'h00;
    {cfg_read_async_in, cfg_edge_falling_in, cfg_burst_cont_in, cfg_vdr_early_in} = 4'h8;
    {sts_cfg_pulse_in, burst_word_ready_in, burst_data_in} = '0;
    read_source_in = SRC_ARRAY;
    foreach (words[i]) words[i] = 16'($random(seed));
    {array_data_in, signature_data_in, protect_data_in, query_data_in, status_data_in} =
      {words[0], words[1], words[2], words[3], words[4]};
    #1 sys_rst_in = 1'b1; // Rising after time zero so every flop sees it
    repeat (6) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    @(negedge clk_sys_in);
    check("powerdown", powerdown_out, 1);
    check("stsclr", status_clear_out, 1);
    check("odlow", {controller_state_out, valid_data_ready_out}, 0);
    fhbs_host_inst.rst(8, 1'b0);
    repeat (60) if (bus_ready_out !== 1'b1) @(negedge clk_sys_in);
    check("ready", bus_ready_out, 1);
    check("mode", read_mode_select_bit_out, 1);
    check("permit", pe_permit_out, 0);
    repeat (2) begin
      a = 21'($random(seed));
      cnt = $random(seed);
      fhbs_host_inst.wr(a, cnt[15:0]);
      check("waddr", cmd_addr_out, a);
      check("wdata", cmd_data_out, cnt[15:0]);
    end
    check("strobes", strobes, 2);
    for (int s = 0; s < 5; s++) begin
      read_source_in = fhbs_rd_src_t'(s);
      fhbs_host_inst.rd(21'(a + s), 2'h0, 10);
      check("rdata", bidir_data_bus_out, words[s]);
      check("raddr", read_addr_out, 21'(a + s));
    end
    pe_busy_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    check("busybit", bidir_data_bus_out[7], 0);
    check("stsbusy", controller_state_oe_out, 1);
    fhbs_host_inst.rd(a, 2'h1, 8);
    check("hiz", bidir_data_bus_oe_out, 0);
    fhbs_host_inst.rd(a, 2'h3, 8);
    check("standby", standby_out, 1);
    fhbs_host_inst.wr(~a, 16'h0000);
    check("opaddr", op_addr_out, a);
    pe_busy_in = 1'b0;
    @(negedge clk_sys_in);
    check("stsidle", controller_state_oe_out, 0);
    $display("Test bus done");
    sts_cfg_pulse_in = 1'b1;
    pulse(sts_cfg_wr_in);
    cnt = 0;
    pulse(pe_done_in);
    repeat (60) begin
      cnt += controller_state_oe_out;
      @(negedge clk_sys_in);
    end
    check("pulse", cnt, 32'(STS_PULSE_CYC));
    {cfg_read_async_in, cfg_burst_cont_in} = 2'h1;
    pulse(cfg_wr_in);
    check("sync", read_mode_select_bit_out, 0);
    a = 21'($random(seed));
    burst_data_in = words[1];
    fhbs_host_inst.rd(a, 2'h0, 8);
    #1 kclk(6);
    check("bactive", burst_active_out, 1);
    check("baddr", burst_addr_out, a);
    check("vdr", valid_data_ready_oe_out, 1);
    check("bdata", bidir_data_bus_out, words[1]);
    check("boe", bidir_data_bus_oe_out, 1);
    burst_word_ready_in = 1'b1;
    kclk(1);
    check("vdrok", valid_data_ready_oe_out, 0);
    check("bnext", burst_addr_out, 21'(a + 1));
    cfg_vdr_early_in = 1'b1;
    pulse(cfg_wr_in);
    kclk(4);
    burst_word_ready_in = 1'b0;
    #1 check("vdrearly", valid_data_ready_oe_out, 1);
    fhbs_host_inst.rd(a, 2'h1, 0);
    kclk(1);
    check("bgate", bidir_data_bus_oe_out, 0);
    pe_busy_in = 1'b1;
    fhbs_host_inst.rd(a, 2'h3, 2);
    fhbs_host_inst.rst(10, 1'b1);
    pe_busy_in = 1'b0;
    repeat (60) if (bus_ready_out !== 1'b1) @(negedge clk_sys_in);
    check("abort", aborts, 1);
    check("mode", read_mode_select_bit_out, 1);
    check("permit", pe_permit_out, 1);
    $display("Test burst and abort done");
    stop_test();
  end
  // Watchdog
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end
endmodule : testbench
